// *** hdl/wutc_pkg.sv ***
// Shared constants and state types for the wake-up threshold register bank.
// Assumes one clock (hclk) and an asynchronous active-low reset on both ends.
package wutc_pkg;
  // Device register offsets
  localparam logic [7:0] X_LOWER_MSB_OFS = 8'h07;
  localparam logic [7:0] X_UPPER_MSB_OFS = 8'h08;
  localparam logic [7:0] Y_LOWER_MSB_OFS = 8'h09;
  localparam logic [7:0] Y_UPPER_MSB_OFS = 8'h0a;
  localparam logic [7:0] WAKE_CTRL_OFS   = 8'h0d;
  localparam logic [7:0] Y_LOW_OFS       = 8'h0e;
  // Device reset values
  localparam logic [7:0] LOWER_MSB_RST = 8'h80;
  localparam logic [7:0] UPPER_MSB_RST = 8'h7f;
  localparam logic [7:0] WAKE_CTRL_RST = 8'h38;
  localparam logic [7:0] Y_LOW_RST     = 8'h38;
  // Field positions
  localparam int ACTIVE_BIT   = 7;
  localparam int ENABLE_BIT   = 6;
  localparam int UPPER_LSB_HI = 5;
  localparam int UPPER_LSB_LO = 3;
  localparam int LOWER_LSB_HI = 2;
  localparam int LOWER_LSB_LO = 0;
  localparam int FACTORY_HI   = 7;
  localparam int FACTORY_LO   = 6;
  localparam int THRESH_W     = 11;
  // Controller register byte offsets
  localparam logic [7:0] H_CMD_OFS    = 8'h00;
  localparam logic [7:0] H_STATUS_OFS = 8'h04;
  localparam logic [7:0] H_IRQ_ST_OFS = 8'h08;
  localparam logic [7:0] H_IRQ_EN_OFS = 8'h0c;
  localparam logic [7:0] H_IRQ_CL_OFS = 8'h10;
  localparam logic [7:0] H_CTRL_OFS   = 8'h14;
  // Controller field positions
  localparam int CMD_WE_BIT    = 16;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_INT_BIT    = 16;
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_INT_BIT   = 1;
  localparam int IRQ_W         = 2;
  localparam int CTRL_PREP_BIT = 0;

  typedef struct packed {
    logic [7:0] x_lower_msb;
    logic [7:0] x_upper_msb;
    logic [7:0] y_lower_msb;
    logic [7:0] y_upper_msb;
    logic [5:0] x_low_bits;
    logic       wake_enable;
    logic [7:0] y_thresh_low;
    logic       ack;
    logic [7:0] rdata;
    logic       int_n;
  } wutc_dev_state_t;

  typedef enum logic [1:0] {WUTC_IDLE, WUTC_REQ, WUTC_WAIT} wutc_hstate_t;

  typedef struct packed {
    wutc_hstate_t         fsm;
    logic                 req;
    logic                 we;
    logic [7:0]           addr;
    logic [7:0]           wdata;
    logic [7:0]           rdata;
    logic [IRQ_W-1:0]     irq_stat;
    logic [IRQ_W-1:0]     irq_en;
    logic                 prep_ok;
    logic                 dp_valid;
    logic                 dp_write;
    logic [7:0]           dp_addr;
  } wutc_host_state_t;
endpackage

// *** hdl/wutc_if.sv ***
// Register-access link between controller and sensor register bank.
// Assumes both ends share hclk; req is a one-cycle pulse answered by ack.
interface wutc_if;
  logic       req;
  logic       we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  logic       int_n;

  modport dev  (input req, we, addr, wdata, output ack, rdata, int_n);
  modport host (output req, we, addr, wdata, input ack, rdata, int_n);
endinterface

// *** hdl/wutc_dev.sv ***
// Sensor end: wake-up control and x/y threshold registers with comparator.
// Assumes measurement inputs come from logic on hclk, no synchroniser needed.

// Notes on behaviour
// - Bit 6 enables wake-up, read/write
// - Host selects full or short range first
// - Host sets odd config parity first
// - Interrupt when field at/over upper, at/under lower
// - Threshold interrupts only while disable bit zero
// - Control bits 5:3 hold x upper LSBs
// - Control bits 2:0 hold x lower LSBs
// - Y register bits 5:3 hold y upper LSBs
// - Y register bits 2:0 hold y lower LSBs
// - Host writes factory bits 7:6 unchanged
// - Separate MSB byte joins LSBs per threshold
module wutc_dev #(
  parameter int MEAS_W = wutc_pkg::THRESH_W
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              clk_en,
  wutc_if.dev                    link,
  input  wire logic              range_ok,
  input  wire logic              cfg_parity_flag,
  input  wire logic              int_disable,
  input  wire logic              meas_valid,
  input  wire logic [MEAS_W-1:0] meas_x,
  input  wire logic [MEAS_W-1:0] meas_y,
  output logic                   wake_active_flag
);
  wutc_pkg::wutc_dev_state_t state_reg;
  wutc_pkg::wutc_dev_state_t state_next;

  logic signed [MEAS_W-1:0] x_upper;
  logic signed [MEAS_W-1:0] x_lower;
  logic signed [MEAS_W-1:0] y_upper;
  logic signed [MEAS_W-1:0] y_lower;
  logic                     crossed;
  logic                     wr_en;

  // Full threshold from MSB byte and three LSBs
  function automatic logic [MEAS_W-1:0] join_thresh(input logic [7:0] msb,
                                                    input logic [2:0] lsb);
    join_thresh = MEAS_W'({msb, lsb});
  endfunction

  function automatic logic over_under(input logic signed [MEAS_W-1:0] v,
                                     input logic signed [MEAS_W-1:0] up,
                                     input logic signed [MEAS_W-1:0] lo);
    over_under = (v >= up) || (v <= lo);
  endfunction

  // Active only with a valid range and flagged parity
  assign wake_active_flag = state_reg.wake_enable && range_ok
                            && cfg_parity_flag;

  assign x_upper = join_thresh(state_reg.x_upper_msb, state_reg.x_low_bits[5:3]);
  assign x_lower = join_thresh(state_reg.x_lower_msb, state_reg.x_low_bits[2:0]);
  assign y_upper = join_thresh(state_reg.y_upper_msb, state_reg.y_thresh_low[5:3]);
  assign y_lower = join_thresh(state_reg.y_lower_msb, state_reg.y_thresh_low[2:0]);

  assign crossed = over_under($signed(meas_x), x_upper, x_lower)
                   || over_under($signed(meas_y), y_upper, y_lower);

  assign wr_en = link.req && link.we;

  always_comb begin
    state_next       = state_reg;
    state_next.ack   = link.req;
    state_next.int_n = 1'b1;
    if (wr_en) begin
      unique case (link.addr)
        wutc_pkg::X_LOWER_MSB_OFS: state_next.x_lower_msb = link.wdata;
        wutc_pkg::X_UPPER_MSB_OFS: state_next.x_upper_msb = link.wdata;
        wutc_pkg::Y_LOWER_MSB_OFS: state_next.y_lower_msb = link.wdata;
        wutc_pkg::Y_UPPER_MSB_OFS: state_next.y_upper_msb = link.wdata;
        wutc_pkg::WAKE_CTRL_OFS: begin
          state_next.wake_enable = link.wdata[wutc_pkg::ENABLE_BIT];
          state_next.x_low_bits  = link.wdata[5:0];
        end
        wutc_pkg::Y_LOW_OFS: state_next.y_thresh_low = link.wdata;
        default: ;
      endcase
    end
    if (link.req && !link.we) begin
      unique case (link.addr)
        wutc_pkg::X_LOWER_MSB_OFS: state_next.rdata = state_reg.x_lower_msb;
        wutc_pkg::X_UPPER_MSB_OFS: state_next.rdata = state_reg.x_upper_msb;
        wutc_pkg::Y_LOWER_MSB_OFS: state_next.rdata = state_reg.y_lower_msb;
        wutc_pkg::Y_UPPER_MSB_OFS: state_next.rdata = state_reg.y_upper_msb;
        wutc_pkg::WAKE_CTRL_OFS:   state_next.rdata = {wake_active_flag, state_reg.wake_enable,
                                                       state_reg.x_low_bits};
        wutc_pkg::Y_LOW_OFS:   state_next.rdata = state_reg.y_thresh_low;
        default:               state_next.rdata = 8'h00;
      endcase
    end
    // One-cycle low pulse per crossing measurement
    if (meas_valid && wake_active_flag && !int_disable && crossed) begin
      state_next.int_n = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg.x_lower_msb  <= wutc_pkg::LOWER_MSB_RST;
      state_reg.x_upper_msb  <= wutc_pkg::UPPER_MSB_RST;
      state_reg.y_lower_msb  <= wutc_pkg::LOWER_MSB_RST;
      state_reg.y_upper_msb  <= wutc_pkg::UPPER_MSB_RST;
      state_reg.x_low_bits   <= wutc_pkg::WAKE_CTRL_RST[5:0];
      state_reg.wake_enable  <= wutc_pkg::WAKE_CTRL_RST[wutc_pkg::ENABLE_BIT];
      state_reg.y_thresh_low <= wutc_pkg::Y_LOW_RST;
      state_reg.ack          <= 1'b0;
      state_reg.rdata        <= 8'h00;
      state_reg.int_n        <= 1'b1;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign link.ack   = state_reg.ack;
  assign link.rdata = state_reg.rdata;
  assign link.int_n = state_reg.int_n;
endmodule // wutc_dev

// *** hdl/wutc_host.sv ***
// Controller end: AHB-Lite slave registers driving the register-access link.
// Assumes a single AHB-Lite master issuing single word transfers.
//
// The AHB-Lite register port was chosen for this implementation.
module wutc_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             irq,
  wutc_if.host             link
);
  wutc_pkg::wutc_host_state_t state_reg;
  wutc_pkg::wutc_host_state_t state_next;

  logic                      cmd_go;
  logic [wutc_pkg::IRQ_W-1:0] irq_set;
  logic [7:0]                cmd_wdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irq       = |(state_reg.irq_stat & state_reg.irq_en);

  assign cmd_go = state_reg.dp_valid && state_reg.dp_write
                  && hit(state_reg.dp_addr, wutc_pkg::H_CMD_OFS)
                  && (state_reg.fsm == wutc_pkg::WUTC_IDLE);

  // Protect factory bits and refuse enable before preparation
  always_comb begin
    cmd_wdata = hwdata[7:0];
    if (hwdata[15:8] == wutc_pkg::Y_LOW_OFS) begin
      cmd_wdata[wutc_pkg::FACTORY_HI:wutc_pkg::FACTORY_LO] =
        wutc_pkg::Y_LOW_RST[wutc_pkg::FACTORY_HI:wutc_pkg::FACTORY_LO];
    end
    if (hwdata[15:8] == wutc_pkg::WAKE_CTRL_OFS && !state_reg.prep_ok) begin
      cmd_wdata[wutc_pkg::ENABLE_BIT] = 1'b0;
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[wutc_pkg::IRQ_DONE_BIT] = (state_reg.fsm == wutc_pkg::WUTC_WAIT) && link.ack;
    irq_set[wutc_pkg::IRQ_INT_BIT]  = !link.int_n;
  end

  always_comb begin
    state_next          = state_reg;
    state_next.req      = 1'b0;
    state_next.dp_valid = hsel && hready && htrans[1];
    state_next.dp_write = hwrite;
    state_next.dp_addr  = haddr[7:0];
    unique case (state_reg.fsm)
      wutc_pkg::WUTC_IDLE: begin
        if (cmd_go) begin
          state_next.fsm   = wutc_pkg::WUTC_REQ;
          state_next.req   = 1'b1;
          state_next.we    = hwdata[wutc_pkg::CMD_WE_BIT];
          state_next.addr  = hwdata[15:8];
          state_next.wdata = cmd_wdata;
        end
      end
      wutc_pkg::WUTC_REQ:  state_next.fsm = wutc_pkg::WUTC_WAIT;
      wutc_pkg::WUTC_WAIT: begin
        if (link.ack) begin
          state_next.fsm = wutc_pkg::WUTC_IDLE;
          if (!state_reg.we) begin
            state_next.rdata = link.rdata;
          end
        end
      end
      default: state_next.fsm = wutc_pkg::WUTC_IDLE;
    endcase
    if (state_reg.dp_valid && state_reg.dp_write) begin
      if (hit(state_reg.dp_addr, wutc_pkg::H_IRQ_EN_OFS)) begin
        state_next.irq_en = hwdata[wutc_pkg::IRQ_W-1:0];
      end
      if (hit(state_reg.dp_addr, wutc_pkg::H_IRQ_CL_OFS)) begin
        state_next.irq_stat = state_reg.irq_stat & ~hwdata[wutc_pkg::IRQ_W-1:0];
      end
      if (hit(state_reg.dp_addr, wutc_pkg::H_CTRL_OFS)) begin
        state_next.prep_ok = hwdata[wutc_pkg::CTRL_PREP_BIT];
      end
    end
    // Set wins over clear
    state_next.irq_stat = state_next.irq_stat | irq_set;
  end

  always_comb begin
    hrdata = 32'h0000_0000;
    if (state_reg.dp_valid && !state_reg.dp_write) begin
      unique case (state_reg.dp_addr)
        wutc_pkg::H_CMD_OFS:    hrdata = {15'h0000, state_reg.we, state_reg.addr,
                                          state_reg.wdata};
        wutc_pkg::H_STATUS_OFS: hrdata = {15'h0000, !link.int_n, state_reg.rdata, 7'h00,
                                          state_reg.fsm != wutc_pkg::WUTC_IDLE};
        wutc_pkg::H_IRQ_ST_OFS: hrdata = {30'h0000_0000, state_reg.irq_stat};
        wutc_pkg::H_IRQ_EN_OFS: hrdata = {30'h0000_0000, state_reg.irq_en};
        wutc_pkg::H_CTRL_OFS:   hrdata = {31'h0000_0000, state_reg.prep_ok};
        default:                hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '{fsm: wutc_pkg::WUTC_IDLE, default: '0};
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign link.req   = state_reg.req;
  assign link.we    = state_reg.we;
  assign link.addr  = state_reg.addr;
  assign link.wdata = state_reg.wdata;
endmodule // wutc_host

// *** tb/wutc_chk.sv ***
// Checker for the register-access link between controller and device.
// Assumes one clock hclk and an asynchronous active-low reset hresetn.
module wutc_chk (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       req,
  input wire logic       we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata,
  input wire logic       int_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_ack_after_req; req |=> ack; endproperty
  a_ack_after_req: assert property (p_ack_after_req) else $error("ack late");

  property p_ack_cause; ack |-> $past(req); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without req");

  property p_req_alone; req |-> !ack; endproperty
  a_req_alone: assert property (p_req_alone) else $error("req during ack");

  property p_req_gap; req |=> !req [*2]; endproperty
  a_req_gap: assert property (p_req_gap) else $error("req too soon");

  property p_int_pulse; !int_n |=> int_n; endproperty
  a_int_pulse: assert property (p_int_pulse) else $error("int_n too long");

  property p_factory_bits;
    req && we && addr == wutc_pkg::Y_LOW_OFS |-> wdata[7:6] == wutc_pkg::Y_LOW_RST[7:6];
  endproperty
  a_factory_bits: assert property (p_factory_bits) else $error("factory bits written");

  property p_unmapped;
    ack && !$past(we) && !($past(addr) inside {8'h07, 8'h08, 8'h09, 8'h0a, 8'h0d, 8'h0e})
      |-> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_rdata_hold; $changed(rdata) |-> ack; endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved without ack");
endmodule // wutc_chk

// *** tb/wake_up_threshold_config_tb.sv ***
// Bench for controller and device joined by the link; drives AHB-Lite and measurements.
// Assumes hreadyout feeds hready and the controller register map of the package.
module wake_up_threshold_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic        meas_valid, range_ok, par_ok, int_dis, wake_active_flag, rdy_s, en;
  logic [31:0] haddr, hwdata, hrdata, hr_s;
  logic [1:0]  htrans;
  logic [10:0] mx, my;
  int          miscompares, check_count, n_int, cyc;
  logic [7:0]  ofs [7] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0d, 8'h0e, 8'h0b};
  logic [7:0]  rst [7] = '{8'h80, 8'h7f, 8'h80, 8'h7f, 8'h38, 8'h38, 8'h00};
  logic [7:0]  mv [4] = '{8'hf0, 8'h10, 8'hf0, 8'h10};
  // Fields: x, y, disable, expected pulses; upper 131, lower -123
  logic [23:0] mt [7] = '{{11'h083, 11'h000, 2'b01}, {11'h082, 11'h000, 2'b00},
    {11'h785, 11'h000, 2'b01}, {11'h786, 11'h000, 2'b00}, {11'h000, 11'h083, 2'b01},
    {11'h000, 11'h785, 2'b01}, {11'h0c8, 11'h000, 2'b10}};

  wutc_if link_if ();
  wutc_host wutc_host_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .link(link_if.host));
  wutc_dev wutc_dev_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(en), .link(link_if.dev),
    .range_ok(range_ok), .cfg_parity_flag(par_ok), .int_disable(int_dis),
    .meas_valid(meas_valid), .meas_x(mx), .meas_y(my), .wake_active_flag(wake_active_flag));
  wutc_chk wutc_chk_inst (.hclk(hclk), .hresetn(hresetn), .req(link_if.req), .we(link_if.we),
    .addr(link_if.addr), .wdata(link_if.wdata), .ack(link_if.ack), .rdata(link_if.rdata),
    .int_n(link_if.int_n));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // Mid-cycle copies avoid races with the design's edge updates
  always @(negedge hclk) begin
    hr_s <= hrdata;
    rdy_s <= hreadyout;
    if (link_if.int_n === 1'b0) n_int <= n_int + 1;
  end

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares = miscompares + 1;
      test_done();
    end
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task test_done;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (rdy_s !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (rdy_s !== 1'b1) @(posedge hclk);
    r = hr_s;
  endtask

  task dev(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    logic [31:0] s;
    ahb(1'b1, wutc_pkg::H_CMD_OFS, {15'h0, w, a, d}, s);
    s = 32'h1;
    while (s[wutc_pkg::ST_BUSY_BIT] !== 1'b0) ahb(1'b0, wutc_pkg::H_STATUS_OFS, 32'h0, s);
    r = s[15:8];
  endtask

  task meas(input logic [23:0] m);
    int b;
    b = n_int;
    @(posedge hclk);
    mx         <= m[23:13];
    my         <= m[12:2];
    int_dis    <= m[1];
    meas_valid <= 1'b1;
    @(posedge hclk);
    meas_valid <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(8'(n_int - b), {7'h0, m[0]});
  endtask

  initial begin
    logic [7:0]  r;
    logic [31:0] s;
    hresetn     = 1'b0;
    hsel        = 1'b0;
    haddr       = 32'h0;
    htrans      = 2'b00;
    hwrite      = 1'b0;
    hwdata      = 32'h0;
    meas_valid  = 1'b0;
    mx          = 11'h0;
    my          = 11'h0;
    range_ok    = 1'b0;
    par_ok      = 1'b0;
    int_dis     = 1'b0;
    en          = 1'b1;
    miscompares = 0;
    check_count = 0;
    n_int       = 0;
    cyc         = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (ofs[i]) begin
      dev(1'b0, ofs[i], 8'h00, r);
      chk(r, rst[i]);
    end
    range_ok <= 1'b1;
    par_ok <= 1'b1;
    dev(1'b1, wutc_pkg::WAKE_CTRL_OFS, 8'hff, r);
    dev(1'b0, wutc_pkg::WAKE_CTRL_OFS, 8'h00, r);
    chk(r, 8'h3f);
    ahb(1'b1, wutc_pkg::H_CTRL_OFS, 32'h1, s);
    dev(1'b1, wutc_pkg::WAKE_CTRL_OFS, 8'h5d, r);
    dev(1'b0, wutc_pkg::WAKE_CTRL_OFS, 8'h00, r);
    chk(r, 8'hdd);
    chk({7'h0, wake_active_flag}, 8'h01);
    range_ok <= 1'b0;
    dev(1'b0, wutc_pkg::WAKE_CTRL_OFS, 8'h00, r);
    chk(r, 8'h5d);
    range_ok <= 1'b1;
    dev(1'b1, wutc_pkg::Y_LOW_OFS, 8'hdd, r);
    dev(1'b0, wutc_pkg::Y_LOW_OFS, 8'h00, r);
    chk(r, 8'h1d);
    for (int i = 0; i < 4; i++) begin
      dev(1'b1, ofs[i], mv[i], r);
      dev(1'b0, ofs[i], 8'h00, r);
      chk(r, mv[i]);
    end
    foreach (mt[i]) meas(mt[i]);
    // Frozen clock enable swallows a crossing measurement
    en <= 1'b0;
    meas({11'h0c8, 11'h000, 2'b00});
    en <= 1'b1;
    par_ok <= 1'b0;
    meas({11'h0c8, 11'h000, 2'b00});
    ahb(1'b0, wutc_pkg::H_IRQ_ST_OFS, 32'h0, s);
    chk(s[7:0], 8'h03);
    ahb(1'b1, wutc_pkg::H_IRQ_EN_OFS, 32'h2, s);
    @(negedge hclk);
    chk({7'h0, irq}, 8'h01);
    ahb(1'b1, wutc_pkg::H_IRQ_EN_OFS, 32'h0, s);
    @(negedge hclk);
    chk({7'h0, irq}, 8'h00);
    ahb(1'b1, wutc_pkg::H_IRQ_EN_OFS, 32'h2, s);
    ahb(1'b1, wutc_pkg::H_IRQ_CL_OFS, 32'h2, s);
    ahb(1'b0, wutc_pkg::H_IRQ_ST_OFS, 32'h0, s);
    chk(s[7:0], 8'h01);
    chk({7'h0, irq}, 8'h00);
    ahb(1'b0, 8'h18, 32'h0, s);
    chk(s[7:0], 8'h00);
    chk({7'h0, hresp}, 8'h00);
    test_done();
  end
endmodule // wake_up_threshold_config_tb
